// ---- ohz_ctrl.sv ----
// Output short detection and high-impedance control with Avalon-MM registers
// Operation
// - Any compared pair both low sets flag
// - Flag clears by writing 0 after reading 1
// - Reserved bits read zero, written zero
// - Compare enable plus interrupt enable plus flag requests high-impedance
// - No high-impedance request without interrupt enable
// - Interrupt request coincides with high-impedance request
// - Pair already low at enable: flag immediately
// - Short high-impedance sets port bits 15-11, 9
// - Interrupt enable gates short_irq and short_hiz_req; the short status bit feeding irq sets without it
// - Emergency input detect floats the GPIO/timer-assigned high-current pins
// - Detect forcing only for GPIO/timer-assigned pins
// - Mode 00 detects falling edge per pin
// - Level modes need sixteen consecutive low samples
module ohz_ctrl (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  // Timer complementary output levels
  input  wire logic [ohz_pkg::N_PAIR-1:0]  pair_out_a,
  input  wire logic [ohz_pkg::N_PAIR-1:0]  pair_out_b,
  // Emergency inputs and pin assignment
  input  wire logic [ohz_pkg::N_EPIN-1:0]  emergency_input_pin,
  input  wire logic [ohz_pkg::N_HC-1:0]    pin_gpio_or_timer,
  // Protection outputs
  output logic      [ohz_pkg::N_HC-1:0]    hiz_pin,
  output logic                             short_hiz_req,
  output logic                             short_irq,
  output logic      [15:0]                 port_e_data_set,
  // Interrupt
  output logic                             irq
);

  ohz_pkg::ohz_state_t   s_ff;
  ohz_pkg::ohz_state_t   nxt_s;
  ohz_pkg::ohz_bus_req_t bus;

  logic                       req_any;
  logic                       acc;
  logic                       wr_ctrl;
  logic                       wr_det;
  logic                       wr_stat;
  logic                       wr_mask;
  logic                       rd_ctrl;
  logic                       rd_det;
  logic                       cmp_en_eff;
  logic                       pair_low;
  logic                       short_now;
  logic                       shz;
  logic [ohz_pkg::N_EPIN-1:0] det_hit;
  logic [15:0]                ctrl_view;
  logic [15:0]                det_view;

  // ==========================================================================
  // Helpers
  function automatic logic tick_sel(input logic [1:0] mode, input logic [6:0] presc);
    logic t;
    t = 1'b0;
    case (mode)
      ohz_pkg::MODE_DIV8:   t = (presc[2:0] == ohz_pkg::DIV8_LAST[2:0]);
      ohz_pkg::MODE_DIV16:  t = (presc[3:0] == ohz_pkg::DIV16_LAST[3:0]);
      ohz_pkg::MODE_DIV128: t = (presc == ohz_pkg::DIV128_LAST);
      default:              t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic is_wr(input ohz_pkg::ohz_bus_req_t b, input logic [4:0] a,
                                 input logic go);
    return go && b.write && (b.address[4:2] == a[4:2]);
  endfunction

  // ==========================================================================
  // Bus decode; every access waits exactly one cycle
  assign bus.address    = avs_address;
  assign bus.read       = avs_read;
  assign bus.write      = avs_write;
  assign bus.writedata  = avs_writedata;
  assign bus.byteenable = avs_byteenable;

  assign req_any         = bus.read | bus.write;
  assign acc             = req_any & s_ff.ack;
  assign avs_waitrequest = req_any & ~s_ff.ack;
  assign avs_readdata    = s_ff.rdata;

  assign wr_ctrl = is_wr(bus, ohz_pkg::ADDR_CTRL, acc);
  assign wr_det  = is_wr(bus, ohz_pkg::ADDR_DETECT, acc);
  assign wr_stat = is_wr(bus, ohz_pkg::ADDR_IRQ_STAT, acc);
  assign wr_mask = is_wr(bus, ohz_pkg::ADDR_IRQ_MASK, acc);
  assign rd_ctrl = acc && bus.read && (bus.address[4:2] == ohz_pkg::ADDR_CTRL[4:2]);
  assign rd_det  = acc && bus.read && (bus.address[4:2] == ohz_pkg::ADDR_DETECT[4:2]);

  // ==========================================================================
  // Register views
  always_comb
  begin
    ctrl_view = 16'h0000;
    ctrl_view[ohz_pkg::FLAG_BIT]   = s_ff.short_flag;
    ctrl_view[ohz_pkg::CMP_EN_BIT] = s_ff.cmp_en;
    ctrl_view[ohz_pkg::IRQ_EN_BIT] = s_ff.irq_en;
    det_view = {s_ff.det_flag, 4'h0, s_ff.det_mode};
  end

  // ==========================================================================
  // Short compare
  // Compare follows the value being written so a pair already low is caught
  // at the same edge that enables the compare
  assign cmp_en_eff = (wr_ctrl && bus.byteenable[1]) ? bus.writedata[ohz_pkg::CMP_EN_BIT]
                                                     : s_ff.cmp_en;
  assign pair_low   = |(~pair_out_a & ~pair_out_b);
  assign short_now  = cmp_en_eff & pair_low;

  // Both outputs share one term: the request and the interrupt move together
  assign shz           = s_ff.short_flag & s_ff.cmp_en & s_ff.irq_en;
  assign short_hiz_req = shz;
  assign short_irq     = shz;
  assign port_e_data_set = s_ff.pe_set;
  assign irq           = |(s_ff.irq_stat & s_ff.irq_mask);

  // ==========================================================================
  // High-impedance per pin
  genvar g;
  generate
    for (g = 0; g < ohz_pkg::N_HC; g++)
    begin : g_hiz
      assign hiz_pin[g] = shz | ((|s_ff.det_flag) & pin_gpio_or_timer[g]);
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb
  begin
    nxt_s         = s_ff;
    det_hit       = '0;
    nxt_s.ack     = req_any & ~s_ff.ack;
    nxt_s.presc   = s_ff.presc + 7'h01;
    nxt_s.shz_prev = shz;
    nxt_s.pe_set  = (shz && !s_ff.shz_prev) ? ohz_pkg::PE_SET_MASK : 16'h0000;

    // Read data is latched one edge ahead of the accepting edge
    if (nxt_s.ack && bus.read)
    begin
      case (bus.address[4:2])
        ohz_pkg::ADDR_CTRL[4:2]:     nxt_s.rdata = {16'h0000, ctrl_view};
        ohz_pkg::ADDR_DETECT[4:2]:   nxt_s.rdata = {16'h0000, det_view};
        ohz_pkg::ADDR_IRQ_STAT[4:2]: nxt_s.rdata = {30'h0, s_ff.irq_stat};
        ohz_pkg::ADDR_IRQ_MASK[4:2]: nxt_s.rdata = {30'h0, s_ff.irq_mask};
        default:                     nxt_s.rdata = ohz_pkg::RDATA_RST;
      endcase
    end

    // Control register
    if (wr_ctrl && bus.byteenable[1])
    begin
      nxt_s.cmp_en = bus.writedata[ohz_pkg::CMP_EN_BIT];
      nxt_s.irq_en = bus.writedata[ohz_pkg::IRQ_EN_BIT];
      // Writing one to the flag has no effect
      if (!bus.writedata[ohz_pkg::FLAG_BIT] && s_ff.flag_armed)
      begin
        nxt_s.short_flag = 1'b0;
        nxt_s.flag_armed = 1'b0;
      end
    end
    if (rd_ctrl && s_ff.short_flag)
      nxt_s.flag_armed = 1'b1;
    if (short_now)
      nxt_s.short_flag = 1'b1;

    // Emergency input detection
    for (int i = 0; i < ohz_pkg::N_EPIN; i++)
    begin
      nxt_s.prev_pin[i] = emergency_input_pin[i];
      if (s_ff.det_mode[2*i +: 2] == ohz_pkg::MODE_EDGE)
      begin
        nxt_s.low_cnt[i] = 4'h0;
        det_hit[i] = s_ff.prev_pin[i] & ~emergency_input_pin[i];
      end
      else if (tick_sel(s_ff.det_mode[2*i +: 2], s_ff.presc))
      begin
        // One high sample restarts the run
        if (emergency_input_pin[i])
          nxt_s.low_cnt[i] = 4'h0;
        else if (s_ff.low_cnt[i] == ohz_pkg::SAMPLES_LAST)
        begin
          nxt_s.low_cnt[i] = 4'h0;
          det_hit[i] = 1'b1;
        end
        else
          nxt_s.low_cnt[i] = s_ff.low_cnt[i] + 4'h1;
      end
      if (wr_det && bus.byteenable[1] && !bus.writedata[ohz_pkg::DET_FLAG_LSB + i]
          && s_ff.det_armed[i])
      begin
        nxt_s.det_flag[i]  = 1'b0;
        nxt_s.det_armed[i] = 1'b0;
      end
      if (rd_det && s_ff.det_flag[i])
        nxt_s.det_armed[i] = 1'b1;
      if (det_hit[i])
        nxt_s.det_flag[i] = 1'b1;
    end
    if (wr_det && bus.byteenable[0])
      nxt_s.det_mode = bus.writedata[7:0];

    // Interrupt status and mask; a new event beats a same-cycle clear
    if (wr_mask && bus.byteenable[0])
      nxt_s.irq_mask = bus.writedata[ohz_pkg::N_IRQ-1:0];
    if (wr_stat && bus.byteenable[0])
      nxt_s.irq_stat = s_ff.irq_stat & ~bus.writedata[ohz_pkg::N_IRQ-1:0];
    if (short_now && !s_ff.short_flag)
      nxt_s.irq_stat[ohz_pkg::IRQ_SHORT] = 1'b1;
    if (|det_hit)
      nxt_s.irq_stat[ohz_pkg::IRQ_DETECT] = 1'b1;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_ff           <= '0;
      s_ff.det_mode  <= ohz_pkg::DET_MODE_RST;
      s_ff.presc     <= ohz_pkg::PRESC_RST;
      s_ff.rdata     <= ohz_pkg::RDATA_RST;
    end
    else
      s_ff <= nxt_s;
  end

endmodule

// ---- ohz_pkg.sv ----
// Constants and carrier types for the output short / high-impedance controller
package ohz_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [4:0] ADDR_CTRL      = 5'h00;
  localparam logic [4:0] ADDR_DETECT    = 5'h04;
  localparam logic [4:0] ADDR_IRQ_STAT  = 5'h08;
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h0c;

  // ==========================================================================
  // Field positions
  localparam int FLAG_BIT     = 15;
  localparam int CMP_EN_BIT   = 9;
  localparam int IRQ_EN_BIT   = 8;
  localparam int DET_FLAG_LSB = 12;
  localparam int IRQ_SHORT    = 0;
  localparam int IRQ_DETECT   = 1;

  // ==========================================================================
  // Sizes and encodings
  localparam int N_PAIR = 3;
  localparam int N_EPIN = 4;
  localparam int N_HC   = 6;
  localparam int N_IRQ  = 2;
  localparam logic [3:0]  SAMPLES_LAST = 4'hf;
  localparam logic [15:0] PE_SET_MASK  = 16'hfa00;
  localparam logic [1:0]  MODE_EDGE    = 2'h0;
  localparam logic [1:0]  MODE_DIV8    = 2'h1;
  localparam logic [1:0]  MODE_DIV16   = 2'h2;
  localparam logic [1:0]  MODE_DIV128  = 2'h3;
  localparam logic [6:0]  DIV8_LAST    = 7'h07;
  localparam logic [6:0]  DIV16_LAST   = 7'h0f;
  localparam logic [6:0]  DIV128_LAST  = 7'h7f;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  DET_MODE_RST = 8'h00;
  localparam logic [6:0]  PRESC_RST    = 7'h00;
  localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ohz_bus_req_t;

  typedef struct packed {
    logic                    cmp_en;
    logic                    irq_en;
    logic                    short_flag;
    logic                    flag_armed;
    logic [N_EPIN-1:0]       det_flag;
    logic [N_EPIN-1:0]       det_armed;
    logic [7:0]              det_mode;
    logic [N_EPIN-1:0]       prev_pin;
    logic [N_EPIN-1:0][3:0]  low_cnt;
    logic [6:0]              presc;
    logic [N_IRQ-1:0]        irq_stat;
    logic [N_IRQ-1:0]        irq_mask;
    logic                    shz_prev;
    logic [15:0]             pe_set;
    logic                    ack;
    logic [31:0]             rdata;
  } ohz_state_t;

endpackage

// ---- ohz_ctrl_asserts.sv ----
// Concurrent checks on the ports of the short / high-impedance controller
module ohz_ctrl_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Pins and requests
  input wire logic [2:0]  pair_out_a,
  input wire logic [2:0]  pair_out_b,
  input wire logic [5:0]  pin_gpio_or_timer,
  input wire logic [5:0]  hiz_pin,
  input wire logic        short_hiz_req,
  input wire logic        short_irq,
  input wire logic [15:0] port_e_data_set
);
  logic wr_take_ff;
  logic short_seen_ff;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Causes seen one edge back
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_take_ff    <= 1'b0;
      short_seen_ff <= 1'b0;
    end
    else
    begin
      wr_take_ff    <= avs_write & ~avs_waitrequest;
      short_seen_ff <= |(~pair_out_a & ~pair_out_b);
    end
  end

  // ==========================================================
  // Assertions
  AST_IRQ_WITH_HIZ: assert property (short_irq == short_hiz_req)
    else $error("Short irq and hiz request differ");
  AST_HIZ_ALL_PINS: assert property (short_hiz_req |-> hiz_pin == 6'h3f)
    else $error("Short request left a pin driven");
  AST_PORT_SET: assert property ($rose(short_hiz_req) |=> port_e_data_set == 16'hfa00)
    else $error("Port data bits not set after short");
  AST_PORT_PULSE: assert property (port_e_data_set != 16'h0000 |=> port_e_data_set == 16'h0000)
    else $error("Port data pulse too long");
  AST_RSVD_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[4:2] == 3'h0
    |-> {avs_readdata[31:16], avs_readdata[14:10], avs_readdata[7:0]} == 29'h0)
    else $error("Reserved bits read nonzero");
  AST_CLEAR_BY_WRITE: assert property ($fell(short_hiz_req) |-> wr_take_ff)
    else $error("Short request dropped without a write");
  AST_RISE_CAUSE: assert property ($rose(short_hiz_req) |-> short_seen_ff || wr_take_ff)
    else $error("Short request rose without a cause");
  AST_DETECT_ASSIGNED: assert property (!short_hiz_req |-> (hiz_pin & ~pin_gpio_or_timer) == 6'h00)
    else $error("Unassigned pin floated");

  COV_SHORT: cover property ($rose(short_hiz_req));
  COV_DETECT: cover property (!short_hiz_req && hiz_pin != 6'h00);
  COV_CLEAR: cover property ($fell(short_hiz_req));
endmodule

bind ohz_ctrl ohz_ctrl_asserts u_ohz_ctrl_asserts (.clock, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .pair_out_a, .pair_out_b, .pin_gpio_or_timer,
  .hiz_pin, .short_hiz_req, .short_irq, .port_e_data_set);

// ---- ohz_far_model.sv ----
// Timer output pairs and emergency inputs facing the controller
module ohz_far_model (
  // Commands from the bench
  input wire logic [2:0] short_pair,
  input wire logic [3:0] epin_low,
  // Pins seen by the controller
  output logic     [2:0] pair_out_a,
  output logic     [2:0] pair_out_b,
  output logic     [3:0] emergency_input_pin
);
  // Healthy pairs stay complementary; emergency lines idle pulled high
  assign pair_out_a          = ~short_pair;
  assign pair_out_b          = 3'h0;
  assign emergency_input_pin = ~epin_low;
endmodule

// ---- tb.sv ----
// Self-checking testbench for the short / high-impedance controller
`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        short_hiz_req, short_irq, irq;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable, epin_low, emergency_input_pin;
  logic [2:0]  short_pair, pair_out_a, pair_out_b;
  logic [5:0]  pin_gpio_or_timer, hiz_pin;
  logic [15:0] port_e_data_set;
  int          errors, total_checks, d;

  ohz_ctrl u_ohz_ctrl (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pair_out_a, .pair_out_b,
    .emergency_input_pin, .pin_gpio_or_timer, .hiz_pin, .short_hiz_req, .short_irq,
    .port_e_data_set, .irq);
  ohz_far_model u_ohz_far_model (.short_pair, .epin_low, .pair_out_a, .pair_out_b,
    .emergency_input_pin);

  always #12.5 clock = ~clock;

  // ==========================================================
  // Bus access and closing
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [15:0] wd);
    avs_address   <= adr;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {16'h0000, wd};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdchk(input logic [4:0] adr, input logic [15:0] exp);
    bus(1'b0, adr, 16'h0000);
    `CHK(rd, {16'h0000, exp})
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdchk(ohz_pkg::ADDR_CTRL, 16'h0000);
    bus(1'b1, 5'h10, 16'hffff);
    rdchk(5'h10, 16'h0000);
    // Upper lane off: enables must not move
    avs_byteenable <= 4'h1;
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0300);
    avs_byteenable <= 4'h3;
    rdchk(ohz_pkg::ADDR_CTRL, 16'h0000);
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0300);
    rdchk(ohz_pkg::ADDR_CTRL, 16'h0300);
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0000);
  endtask

  task automatic t_short_at_enable;
    short_pair <= 3'b001;
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0300);
    @(negedge clock);
    `CHK(port_e_data_set, 16'hfa00)
    `CHK({short_hiz_req, short_irq, hiz_pin}, 8'hff)
    `CHK(irq, 1'b0)
    @(posedge clock);
    short_pair <= 3'b000;
    bus(1'b1, ohz_pkg::ADDR_IRQ_MASK, 16'h0001);
    `CHK(irq, 1'b1)
    rdchk(ohz_pkg::ADDR_IRQ_STAT, 16'h0001);
    bus(1'b1, ohz_pkg::ADDR_IRQ_STAT, 16'h0001);
    `CHK(irq, 1'b0)
    // Flag not yet read as one, so this zero only drops compare enable
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0100);
    `CHK({short_hiz_req, hiz_pin}, 7'h00)
    rdchk(ohz_pkg::ADDR_CTRL, 16'h8100);
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0100);
    rdchk(ohz_pkg::ADDR_CTRL, 16'h0100);
  endtask

  task automatic t_no_enable;
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0200);
    short_pair <= 3'b100;
    @(posedge clock);
    short_pair <= 3'b000;
    @(negedge clock);
    `CHK({short_hiz_req, short_irq, hiz_pin}, 8'h00)
    @(posedge clock);
    // Zero without a prior read of one is ignored
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0200);
    rdchk(ohz_pkg::ADDR_IRQ_STAT, 16'h0001);
    bus(1'b1, ohz_pkg::ADDR_IRQ_STAT, 16'h0001);
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0300);
    `CHK({short_hiz_req, short_irq}, 2'h3)
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0100);
    rdchk(ohz_pkg::ADDR_CTRL, 16'h8100);
    bus(1'b1, ohz_pkg::ADDR_CTRL, 16'h0000);
    rdchk(ohz_pkg::ADDR_CTRL, 16'h0000);
  endtask

  task automatic t_detect_edge;
    pin_gpio_or_timer <= 6'h15;
    epin_low          <= 4'b0100;
    @(posedge clock);
    epin_low <= 4'b0000;
    @(negedge clock);
    `CHK(hiz_pin, 6'h15)
    @(posedge clock);
    rdchk(ohz_pkg::ADDR_DETECT, 16'h4000);
    rdchk(ohz_pkg::ADDR_IRQ_STAT, 16'h0002);
    bus(1'b1, ohz_pkg::ADDR_DETECT, 16'h0000);
    `CHK(hiz_pin, 6'h00)
  endtask

  task automatic t_detect_level;
    for (int m = 1; m < 4; m++)
    begin
      d = (m == 1) ? 8 : (m == 2) ? 16 : 128;
      bus(1'b1, ohz_pkg::ADDR_DETECT, 16'(m));
      epin_low <= 4'b0001;
      repeat (14 * d) @(posedge clock);
      epin_low <= 4'b0000;
      repeat (d) @(posedge clock);
      epin_low <= 4'b0001;
      repeat (14 * d) @(posedge clock);
      rdchk(ohz_pkg::ADDR_DETECT, 16'(m));
      repeat (4 * d) @(posedge clock);
      rdchk(ohz_pkg::ADDR_DETECT, 16'h1000 | 16'(m));
      epin_low <= 4'b0000;
      bus(1'b1, ohz_pkg::ADDR_DETECT, 16'h0000);
    end
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    {clock, rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {short_pair, epin_low, errors, total_checks} = '0;
    avs_byteenable    = 4'h3;
    pin_gpio_or_timer = 6'h3f;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs();
    t_short_at_enable();
    t_no_enable();
    t_detect_edge();
    t_detect_level();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end
endmodule
